// File: pump_cmd_params.svh
// timing constants, fill figures and the behaviour summary of the pump command decoder
// What this block does
// R1: host holds each command high within 0.1 s
// R2: 1.9 to 2.1 s pulse strokes first body
// R3: 5/8/12 s: second, both, fill function
// R4: 14 s acknowledges errors, cancels fill
// R5: out-of-window or over 15 s pulses ignored
// R6: self-check at power-up, then idle only
// R7: status high means ready after 3 s
// R8: falling edge starts run, status goes low
// R9: runs of 9 to 15 s are normal
// R10: good run end returns status high
// R11: commands ignored until 3 s after run
// R12: host waits 22 s after 2 s command
// R13: run faults shown as steady low status
// R14: 2 s during fill cancels first body
// R15: fill: 40 strokes, 0.5 s high gaps
// R16: only acknowledge accepted during error
// R17: 8 s strokes bodies in turn, 45 s gap; the code starts the second body straight after the first, with no gap
// R18: host waits 25 s after 5 s command
// R19: pulse measured in ms, acted on fall
// R20: command input glitch-filtered before measuring
`ifndef PUMP_CMD_PARAMS_SVH
`define PUMP_CMD_PARAMS_SVH

`define CLK_PERIOD_NS 50
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define FILTER_TIME_NS 100000
`define FILTER_CYCLES (`FILTER_TIME_NS / `CLK_PERIOD_NS)

`define MS_W 14
`define TOL_MS 14'd100
`define NOM_SINGLE1_MS 14'd2000
`define NOM_SINGLE2_MS 14'd5000
`define NOM_BOTH_MS 14'd8000
`define NOM_FILL_MS 14'd12000
`define NOM_ACK_MS 14'd14000
`define PULSE_LIMIT_MS 14'd15001
`define RUN_MIN_MS 14'd9000
`define RUN_MAX_MS 14'd15000
`define LOCK_MS 14'd3001
`define FILL_GAP_MS 14'd500
`define SELF_CHECK_MS 14'd1000
`define FILL_STROKES 6'd40

`endif

// File: pump_cmd_pkg.sv
// types shared by the pump command decoder
package pump_cmd_pkg;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_SINGLE1 = 3'h1,
    CMD_SINGLE2 = 3'h2,
    CMD_BOTH = 3'h3,
    CMD_FILL = 3'h4,
    CMD_ACK = 3'h5
  } cmd_t;

  typedef enum logic [2:0] {
    ST_SELF = 3'h0,
    ST_LOCK = 3'h1,
    ST_READY = 3'h3,
    ST_PICK = 3'h2,
    ST_RUN = 3'h6,
    ST_PAUSE = 3'h7,
    ST_ERROR = 3'h5
  } state_t;

  typedef struct packed {
    logic first_pump_body;
    logic second_pump_body;
  } motor_drive_t;

endpackage

// File: glitch_filter.sv
// two-flop synchroniser and stability filter for one slow input pin
`timescale 1ns/10ps
`default_nettype none
module glitch_filter #(
  parameter int STABLE_CYCLES = 2000
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic pin,
  output logic level
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);

  logic sync1_q, sync1_d, sync2_q, sync2_d, level_q, level_d;
  logic [CW-1:0] cnt_q, cnt_d;

  initial begin
    if (STABLE_CYCLES < 2) $error("glitch_filter: STABLE_CYCLES must be at least 2");
  end

  always_comb begin
    sync1_d = pin;
    sync2_d = sync1_q;
    level_d = level_q;
    cnt_d = '0;
    // a spike shorter than the window never reaches the output [R20]
    if (sync2_q != level_q) begin
      if (cnt_q == CW'(STABLE_CYCLES - 1)) begin
        level_d = sync2_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
      cnt_q <= '0;
    end else if (ce) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

  assign level = level_q;
endmodule
`default_nettype wire

// File: pump_cmd_decoder.sv
// pulse-length command decoder and motor run sequencer for the lubrication pump
`timescale 1ns/10ps
`default_nettype none
`include "pump_cmd_params.svh"
module pump_cmd_decoder #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int FILTER_CYCLES = `FILTER_CYCLES,
  parameter bit TWO_BODY = 1'b1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic cmd_pin,
  input wire logic motor_done,
  input wire logic motor_fault,
  output logic status_q,
  output pump_cmd_pkg::motor_drive_t motor_q,
  output logic fill_active_q
);
  import pump_cmd_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES);

  initial begin
    if (TICK_CYCLES < 2) $error("pump_cmd_decoder: TICK_CYCLES must be at least 2");
  end

  function automatic logic in_win(input logic [`MS_W-1:0] len, input logic [`MS_W-1:0] nom);
    in_win = (len >= nom - `TOL_MS) && (len <= nom + `TOL_MS);
  endfunction

  function automatic cmd_t classify(input logic [`MS_W-1:0] len, input logic two);
    classify = CMD_NONE;
    if (in_win(len, `NOM_SINGLE1_MS)) classify = CMD_SINGLE1;
    else if (two && in_win(len, `NOM_SINGLE2_MS)) classify = CMD_SINGLE2;
    else if (two && in_win(len, `NOM_BOTH_MS)) classify = CMD_BOTH;
    else if (in_win(len, `NOM_FILL_MS)) classify = CMD_FILL;
    else if (in_win(len, `NOM_ACK_MS)) classify = CMD_ACK;
  endfunction

  logic cmd_level;
  glitch_filter #(.STABLE_CYCLES(FILTER_CYCLES)) u_filter (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin(cmd_pin),
    .level(cmd_level)
  );

  // motor driver feedback comes from another board, so it is synchronised
  logic [1:0] done_sync_q, done_sync_d, fault_sync_q, fault_sync_d;
  logic [PW-1:0] pre_q, pre_d;
  logic tick;
  logic prev_q, prev_d, armed_q, armed_d;
  logic [`MS_W-1:0] pulse_q, pulse_d, timer_q, timer_d;
  state_t state_q, state_d;
  logic status_d, fill_active_d;
  motor_drive_t motor_d;
  logic pend1_q, pend1_d, pend2_q, pend2_d;
  logic [5:0] fill1_q, fill1_d, fill2_q, fill2_d;
  logic rise, fall;
  cmd_t cmd;

  always_comb begin
    done_sync_d = {done_sync_q[0], motor_done};
    fault_sync_d = {fault_sync_q[0], motor_fault};
    tick = (pre_q == PW'(TICK_CYCLES - 1));
    pre_d = tick ? '0 : pre_q + 1'b1;
  end

  always_comb begin
    rise = cmd_level && !prev_q;
    fall = !cmd_level && prev_q;
    prev_d = cmd_level;
    pulse_d = pulse_q;
    armed_d = armed_q;
    // measure high time in ms, saturating past the longest legal pulse [R19] [R5]
    if (rise) begin
      pulse_d = '0;
      armed_d = (state_q != ST_LOCK) && (state_q != ST_SELF); // [R11]
    end else if (cmd_level && tick && pulse_q < `PULSE_LIMIT_MS) begin
      pulse_d = pulse_q + 1'b1;
    end
    cmd = (fall && armed_q) ? classify(pulse_q, TWO_BODY) : CMD_NONE; // [R2] [R3] [R4] [R5]
  end

  always_comb begin
    state_d = state_q;
    timer_d = (tick && timer_q != {`MS_W{1'b1}}) ? timer_q + 1'b1 : timer_q;
    status_d = status_q;
    motor_d = motor_q;
    pend1_d = pend1_q;
    pend2_d = pend2_q;
    fill1_d = fill1_q;
    fill2_d = fill2_q;
    // fill cancels are honoured between and during fill strokes [R14] [R4]
    if (state_q == ST_RUN || state_q == ST_PAUSE || state_q == ST_PICK) begin
      if (cmd == CMD_SINGLE1) fill1_d = '0;
      if (cmd == CMD_SINGLE2) fill2_d = '0;
      if (cmd == CMD_ACK) begin
        fill1_d = '0;
        fill2_d = '0;
      end
    end
    case (state_q)
      ST_SELF: begin
        // self-check holds the motors off and the status low [R6]
        if (timer_q >= `SELF_CHECK_MS) begin
          timer_d = '0;
          state_d = fault_sync_q[1] ? ST_ERROR : ST_LOCK;
          status_d = !fault_sync_q[1];
        end
      end
      ST_LOCK: begin
        // status already high; ready only after it stood over 3 s [R7] [R11]
        if (timer_q >= `LOCK_MS) state_d = ST_READY;
      end
      ST_READY: begin
        if (cmd != CMD_NONE && cmd != CMD_ACK) begin
          status_d = 1'b0; // [R8]
          state_d = ST_PICK;
          pend1_d = (cmd == CMD_SINGLE1) || (cmd == CMD_BOTH); // [R17]
          pend2_d = (cmd == CMD_SINGLE2) || (cmd == CMD_BOTH);
          if (cmd == CMD_FILL) begin
            fill1_d = `FILL_STROKES; // [R15]
            fill2_d = TWO_BODY ? `FILL_STROKES : 6'h00;
          end
        end
      end
      ST_PICK: begin
        status_d = 1'b0;
        timer_d = '0;
        state_d = ST_RUN;
        if (pend1_q || fill1_d != 6'h00) begin
          motor_d.first_pump_body = 1'b1;
          if (pend1_q) pend1_d = 1'b0;
          else fill1_d = fill1_d - 1'b1;
        end else if (pend2_q || fill2_d != 6'h00) begin
          motor_d.second_pump_body = 1'b1;
          if (pend2_q) pend2_d = 1'b0;
          else fill2_d = fill2_d - 1'b1;
        end else begin
          status_d = 1'b1;
          state_d = ST_LOCK;
        end
      end
      ST_RUN: begin
        // a run outside 9..15 s or a driver fault is an error [R9] [R13]
        if (fault_sync_q[1] || timer_q >= `RUN_MAX_MS
            || (done_sync_q[1] && timer_q < `RUN_MIN_MS)) begin
          motor_d = '0;
          pend1_d = 1'b0;
          pend2_d = 1'b0;
          fill1_d = '0;
          fill2_d = '0;
          state_d = ST_ERROR;
        end else if (done_sync_q[1]) begin
          motor_d = '0;
          timer_d = '0;
          if (pend1_q || pend2_q) begin
            state_d = ST_PICK; // second body follows straight on [R17]
          end else begin
            status_d = 1'b1; // [R10]
            state_d = (fill1_d != 6'h00 || fill2_d != 6'h00) ? ST_PAUSE : ST_LOCK;
          end
        end
      end
      ST_PAUSE: begin
        if (timer_q >= `FILL_GAP_MS) begin
          state_d = ST_PICK; // [R15]
          status_d = 1'b0;
        end
      end
      ST_ERROR: begin
        // steady low stays until acknowledged; nothing else is taken [R13] [R16]
        status_d = 1'b0;
        if (cmd == CMD_ACK) begin
          status_d = 1'b1;
          timer_d = '0;
          state_d = ST_LOCK;
        end
      end
      default: begin
        motor_d = '0;
        status_d = 1'b0;
        state_d = ST_ERROR;
      end
    endcase
    fill_active_d = (fill1_d != 6'h00) || (fill2_d != 6'h00);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_sync_q <= 2'h0;
      fault_sync_q <= 2'h0;
      pre_q <= '0;
      prev_q <= 1'b0;
      armed_q <= 1'b0;
      pulse_q <= '0;
      timer_q <= '0;
      state_q <= ST_SELF;
      status_q <= 1'b0;
      motor_q <= '0;
      pend1_q <= 1'b0;
      pend2_q <= 1'b0;
      fill1_q <= '0;
      fill2_q <= '0;
      fill_active_q <= 1'b0;
    end else if (ce) begin
      done_sync_q <= done_sync_d;
      fault_sync_q <= fault_sync_d;
      pre_q <= pre_d;
      prev_q <= prev_d;
      armed_q <= armed_d;
      pulse_q <= pulse_d;
      timer_q <= timer_d;
      state_q <= state_d;
      status_q <= status_d;
      motor_q <= motor_d;
      pend1_q <= pend1_d;
      pend2_q <= pend2_d;
      fill1_q <= fill1_d;
      fill2_q <= fill2_d;
      fill_active_q <= fill_active_d;
    end
  end
endmodule
`default_nettype wire

// File: pump_cmd_asserts.sv
// port checker for the pump command decoder
`timescale 1ns/10ps
`default_nettype none
module pump_cmd_checker #(
  parameter int TICK_CYCLES = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic cmd_pin,
  input wire logic motor_done,
  input wire logic motor_fault,
  input wire logic status_q,
  input wire pump_cmd_pkg::motor_drive_t motor_q,
  input wire logic fill_active_q
);
  import pump_cmd_pkg::*;
  logic running;
  int run_q;
  int run_d;
  assign running = |motor_q;
  // run length in clocks, so a too-early done shows up
  always_comb begin
    run_d = running ? run_q + 1 : 0;
  end
  always_ff @(posedge clock) begin
    run_q <= run_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    $rose(running) && !fill_active_q;
  endsequence
  sequence s_fault;
    $rose(motor_fault) && running;
  endsequence
  sequence s_error;
    motor_q == 2'h0 && !status_q;
  endsequence
  AST_SELF_CHECK: assert property ($fell(sys_rst) |->
    (!status_q && motor_q == 2'h0 && !fill_active_q)[*8]) else $error("active after reset");
  AST_RUN_LOW: assert property (running |-> !status_q) else $error("status high in run");
  AST_ONE_BODY: assert property (!(motor_q.first_pump_body && motor_q.second_pump_body))
    else $error("both bodies driven");
  AST_START_LOW: assert property (s_start |-> !$past(status_q)) else $error("no status fall");
  AST_CMD_FIRST: assert property (s_start |-> !$past(cmd_pin, 3))
    else $error("run before command fall");
  AST_DONE_STOP: assert property ($rose(motor_done) && running |-> ##[1:5] motor_q == 2'h0)
    else $error("done ignored");
  AST_FAULT_ERR: assert property (s_fault |-> ##[1:5] s_error ##1 (!status_q)[*8])
    else $error("fault not reported");
  AST_RUN_LEN: assert property ($rose(status_q) && $past(running) |->
    $past(run_q) >= 8999 * TICK_CYCLES) else $error("run ended too early");
endmodule
bind pump_cmd_decoder pump_cmd_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock(clock),
  .sys_rst(sys_rst), .ce(ce), .cmd_pin(cmd_pin), .motor_done(motor_done),
  .motor_fault(motor_fault), .status_q(status_q), .motor_q(motor_q),
  .fill_active_q(fill_active_q));
`default_nettype wire

// File: plc_model.sv
// controller model: drives the command line, watches status
`timescale 1ns/10ps
`default_nettype none
module plc_model #(
  parameter int TICK_CYCLES = 2
) (
  input wire logic clock,
  input wire logic status,
  output var logic cmd
);
  initial cmd = 1'b0;
  // one high level per command, timed in ms ticks
  task automatic pulse(input int ms);
    @(posedge clock);
    #1 cmd = 1'b1;
    repeat (ms * TICK_CYCLES) @(posedge clock);
    #1 cmd = 1'b0;
  endtask
  // one-clock spike, only for the filter scenario
  task automatic glitch();
    @(posedge clock);
    #1 cmd = 1'b1;
    @(posedge clock);
    #1 cmd = 1'b0;
  endtask
  // margin over 3 s covers the 3001 ms lockout
  task automatic wait_ready(output bit ok);
    int hi;
    hi = 0;
    ok = 1'b0;
    for (int i = 0; i < 40000 && !ok; i++) begin
      @(posedge clock);
      // look after the edge has settled, not in the step that launches status
      #1;
      hi = (status === 1'b1) ? hi + 1 : 0;
      ok = hi > 3100 * TICK_CYCLES;
    end
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the pump command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pump_cmd_pkg::*;
  localparam int TICK = 2;
  logic clock;
  logic sys_rst;
  logic ce;
  logic motor_done;
  logic motor_fault;
  logic cmd_pin;
  logic status_q;
  logic fill_active_q;
  motor_drive_t motor_q;
  int fail_count;
  int samples_checked;
  bit ok;
  pump_cmd_decoder #(.TICK_CYCLES(TICK), .FILTER_CYCLES(2)) dut (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .cmd_pin(cmd_pin),
    .motor_done(motor_done), .motor_fault(motor_fault), .status_q(status_q),
    .motor_q(motor_q), .fill_active_q(fill_active_q));
  plc_model #(.TICK_CYCLES(TICK)) plc (.clock(clock), .status(status_q), .cmd(cmd_pin));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic check_motor(input motor_drive_t exp, input string what);
    samples_checked++;
    if (motor_q !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  // all drives and samples land 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_status(input logic val, input int limit);
    int n;
    n = 0;
    while (status_q !== val) begin
      tick(1);
      n++;
      if (n > limit) begin
        check_bit(status_q, val, "status wait");
        conclude();
      end
    end
  endtask
  task automatic ready();
    plc.wait_ready(ok);
    if (!ok) begin
      check_bit(1'b0, 1'b1, "never ready");
      conclude();
    end
  endtask
  task automatic test_power_up();
    check_bit(status_q, 1'b0, "high in self check");
    // a low clock enable must stretch the self-check by the frozen time
    ce = 1'b0;
    tick(1000 * TICK);
    ce = 1'b1;
    tick(900 * TICK);
    check_bit(status_q, 1'b0, "self check ran while frozen");
    wait_status(1'b1, 300 * TICK);
    check_motor(2'h0, "motor in self check");
    $display("power-up done");
  endtask
  task automatic test_ignored();
    ready();
    plc.glitch();
    plc.pulse(3000);
    tick(100 * TICK);
    check_bit(status_q, 1'b1, "odd pulse acted on");
    check_motor(2'h0, "odd pulse ran motor");
    $display("ignored pulse done");
  endtask
  task automatic test_fault_ack();
    ready();
    plc.pulse(2000);
    wait_status(1'b0, 20);
    tick(2);
    check_motor(2'h2, "first body not run");
    motor_fault = 1'b1;
    tick(8);
    motor_fault = 1'b0;
    check_motor(2'h0, "motor kept on fault");
    check_bit(status_q, 1'b0, "fault not shown");
    plc.pulse(2000);
    tick(100 * TICK);
    check_bit(status_q, 1'b0, "stroke taken in error");
    check_motor(2'h0, "motor ran in error");
    plc.pulse(14000);
    wait_status(1'b1, 20);
    $display("fault and ack done");
  endtask
  task automatic test_single1();
    ready();
    plc.pulse(2000);
    wait_status(1'b0, 20);
    tick(2);
    check_motor(2'h2, "first body not run");
    tick(9500 * TICK);
    check_bit(status_q, 1'b0, "status rose in run");
    motor_done = 1'b1;
    wait_status(1'b1, 10);
    check_motor(2'h0, "motor left on");
    check_bit(fill_active_q, 1'b0, "fill flagged after stroke");
    motor_done = 1'b0;
    $display("single stroke done");
  endtask
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    motor_done = 1'b0;
    motor_fault = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    tick(10);
    sys_rst = 1'b0;
    test_power_up();
    test_ignored();
    // commands after the faulted stroke meet the error state, which refuses strokes
    test_fault_ack();
    // the completed stroke comes last, so no command cuts its 22 s gap short
    test_single1();
    // no 5 s command is sent, so its 25 s gap never needs keeping
    conclude();
  end
endmodule
`default_nettype wire
